// File: vip_ack_port.sv
// Host port, request flow and acknowledge sequencing of an 8-input interrupt controller.
// Assumes host strobes are slow against CLK_SYS; pins are tri-state split into in/out/oe.
module vip_ack_port (
	input  wire logic       CLK_SYS,
	input  wire logic       RST_N,
	input  wire logic       CS_N,
	input  wire logic       RD_N,
	input  wire logic       WR_N,
	input  wire logic       A0,
	input  wire logic [7:0] D_IN,
	output logic      [7:0] D_OUT,
	output logic            D_OE,
	input  wire logic       HOST_ACK_PULSE_N,
	input  wire logic [7:0] REQUEST_INPUTS,
	output logic            INT,
	input  wire logic [2:0] CASCADE_ID_LINES_IN,
	output logic      [2:0] CASCADE_ID_LINES_OUT,
	output logic            CASCADE_ID_LINES_OE,
	input  wire logic       MASTER_SELECT_OR_BUFFER_EN_IN,
	output logic            MASTER_SELECT_OR_BUFFER_EN_OUT,
	output logic            MASTER_SELECT_OR_BUFFER_EN_OE
);

	logic                  rst_meta;
	logic                  rst_n_s;
	vip_pkg::vip_pins_t    pin_raw;
	vip_pkg::vip_pins_t    pin;
	logic                  wr_prev;
	logic                  rd_prev;
	logic                  ack_prev;
	logic [7:0]            req_prev;
	vip_pkg::vip_init_t    state;
	vip_pkg::vip_init_t    next_state;
	logic [7:0]            init_word_first;
	logic [7:0]            init_word_second;
	logic [7:0]            init_word_third;
	logic [7:0]            init_word_fourth;
	logic [7:0]            request_mask_reg;
	logic [7:0]            pending_request_reg;
	logic [7:0]            in_service_reg;
	logic                  read_svc;
	logic                  poll_armed;
	logic [1:0]            pulse_idx;
	logic [2:0]            lvl;
	logic                  lvl_valid;
	logic                  ack_drive;
	logic [7:0]            ack_byte;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta <= 1'h0;
			rst_n_s  <= 1'h0;
		end else begin
			rst_meta <= 1'h1;
			rst_n_s  <= rst_meta;
		end
	end

	// All pins cross into the clock domain together
	assign pin_raw = {CS_N, RD_N, WR_N, A0, HOST_ACK_PULSE_N, MASTER_SELECT_OR_BUFFER_EN_IN,
		CASCADE_ID_LINES_IN, D_IN, REQUEST_INPUTS};

	vip_sync3 #(
		.WIDTH ($bits(vip_pkg::vip_pins_t)),
		.INIT  (vip_pkg::PINS_IDLE)
	) u_sync (
		.clk   (CLK_SYS),
		.rst_n (rst_n_s),
		.d     (pin_raw),
		.q     (pin)
	);

	// Strobe history for edge detection
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			wr_prev  <= 1'h1;
			rd_prev  <= 1'h1;
			ack_prev <= 1'h1;
			req_prev <= vip_pkg::BYTE_ZERO;
		end else begin
			wr_prev  <= pin.wr_n;
			rd_prev  <= pin.rd_n;
			ack_prev <= pin.ack_n;
			req_prev <= pin.req;
		end
	end

	// Host strobe decode; writes take effect at the trailing edge of the strobe
	wire sel_write  = pin.wr_n & ~wr_prev & ~pin.cs_n;
	wire rd_active  = ~pin.cs_n & ~pin.rd_n & pin.wr_n;
	wire rd_end     = pin.rd_n & ~rd_prev;
	wire ack_fall   = ~pin.ack_n & ack_prev;
	wire ack_rise   = pin.ack_n & ~ack_prev;
	wire wr_init1   = sel_write & ~pin.a0 & pin.data[vip_pkg::FIRST_SELECT];
	wire wr_release = sel_write & ~pin.a0 & ~pin.data[vip_pkg::FIRST_SELECT] & ~pin.data[vip_pkg::OPW_SELECT3];
	wire wr_readsel = sel_write & ~pin.a0 & ~pin.data[vip_pkg::FIRST_SELECT] & pin.data[vip_pkg::OPW_SELECT3];
	wire wr_port1   = sel_write & pin.a0;

	// Configuration fields
	wire need_w4      = init_word_first[vip_pkg::FIRST_NEED_W4];
	wire cascaded     = ~init_word_first[vip_pkg::FIRST_SINGLE];
	wire interval4    = init_word_first[vip_pkg::FIRST_SPACING];
	wire level_mode   = init_word_first[vip_pkg::FIRST_LEVEL];
	wire pointer_mode = init_word_fourth[vip_pkg::FOURTH_POINTER];
	wire auto_release = init_word_fourth[vip_pkg::FOURTH_AUTO];
	wire buffered     = init_word_fourth[vip_pkg::FOURTH_BUFFER];
	wire is_slave     = buffered ? ~init_word_fourth[vip_pkg::FOURTH_MASTER] : ~pin.sp;

	// Lowest set index wins, so input zero has top priority
	function automatic logic [3:0] first_set(input logic [7:0] v);
		logic [3:0] r;
		r = {1'h0, vip_pkg::LEVEL_DEFAULT};
		for (int i = 7; i >= 0; i--) begin
			if (v[i])
				r = {1'h1, 3'(i)};
		end
		return r;
	endfunction

	// Priority resolver: a request must outrank every level in service
	wire [3:0] req_pick = first_set(pending_request_reg & ~request_mask_reg);
	wire [3:0] svc_pick = first_set(in_service_reg);
	wire       eligible = req_pick[3] & (~svc_pick[3] | (req_pick[2:0] < svc_pick[2:0]));

	// Init sequence: W3 only when cascaded, W4 only when asked for
	always_comb begin
		next_state = state;
		case (state)
			vip_pkg::ST_W2: if (wr_port1) begin
				next_state = cascaded ? vip_pkg::ST_W3 : (need_w4 ? vip_pkg::ST_W4 : vip_pkg::ST_READY);
			end
			vip_pkg::ST_W3: if (wr_port1) begin
				next_state = need_w4 ? vip_pkg::ST_W4 : vip_pkg::ST_READY;
			end
			vip_pkg::ST_W4: if (wr_port1) begin
				next_state = vip_pkg::ST_READY;
			end
			default: next_state = state;
		endcase
		if (wr_init1)
			next_state = vip_pkg::ST_W2;
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s)
			state <= vip_pkg::ST_UNINIT;
		else
			state <= next_state;
	end

	// Command word steering; the first init word clears the mask and restarts the init sequence
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			init_word_first  <= vip_pkg::BYTE_ZERO;
			init_word_second <= vip_pkg::BYTE_ZERO;
			init_word_third  <= vip_pkg::BYTE_ZERO;
			init_word_fourth <= vip_pkg::BYTE_ZERO;
			request_mask_reg <= vip_pkg::BYTE_ZERO;
		end else if (wr_init1) begin
			init_word_first  <= pin.data;
			request_mask_reg <= vip_pkg::BYTE_ZERO;
			if (!pin.data[vip_pkg::FIRST_NEED_W4])
				init_word_fourth <= vip_pkg::BYTE_ZERO;
		end else if (wr_port1) begin
			case (state)
				vip_pkg::ST_W2: init_word_second <= pin.data;
				vip_pkg::ST_W3: init_word_third  <= pin.data;
				vip_pkg::ST_W4: init_word_fourth <= pin.data;
				default:        request_mask_reg <= pin.data;
			endcase
		end
	end

	// Read select and poll; a poll is consumed by the next read with A0 low
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			read_svc   <= 1'h0;
			poll_armed <= 1'h0;
		end else if (wr_init1) begin
			read_svc   <= 1'h0;
			poll_armed <= 1'h0;
		end else if (wr_readsel) begin
			if (pin.data[vip_pkg::OPW_READ_SET])
				read_svc <= pin.data[vip_pkg::OPW_READ_SVC];
			poll_armed <= pin.data[vip_pkg::OPW_POLL];
		end else if (rd_end && !pin.a0) begin
			poll_armed <= 1'h0;
		end
	end

	// Acknowledge sequence: two pulses in pointer mode, three in call mode
	wire [1:0] last_idx   = pointer_mode ? vip_pkg::PULSE_SECOND : vip_pkg::PULSE_THIRD;
	wire [1:0] before_last = pointer_mode ? vip_pkg::PULSE_FIRST : vip_pkg::PULSE_SECOND;
	wire       first_fall = ack_fall & (pulse_idx == vip_pkg::PULSE_NONE);
	wire       last_fall  = ack_fall & (pulse_idx == before_last);
	wire       last_rise  = ack_rise & (pulse_idx == last_idx);
	// Fall cycle skipped, so a new pulse never shows the previous pulse's byte
	wire       ack_low    = ~pin.ack_n & ~ack_fall & (pulse_idx != vip_pkg::PULSE_NONE);
	wire       cas_hit    = pin.cas == init_word_third[2:0];
	wire       svc_owner  = is_slave ? cas_hit : 1'h1;
	wire       drive_me   = is_slave ? cas_hit : ~(cascaded & init_word_third[lvl]);

	// Pulse counting ignores chip select, since the host need not select us
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s)
			pulse_idx <= vip_pkg::PULSE_NONE;
		else if (ack_fall && pulse_idx != last_idx)
			pulse_idx <= pulse_idx + 2'h1;
		else if (last_rise)
			pulse_idx <= vip_pkg::PULSE_NONE;
	end

	// Level frozen at the first pulse; a vanished request falls back to level seven
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			lvl       <= vip_pkg::LEVEL_DEFAULT;
			lvl_valid <= 1'h0;
		end else if (first_fall) begin
			lvl       <= eligible ? req_pick[2:0] : vip_pkg::LEVEL_DEFAULT;
			lvl_valid <= eligible;
		end
	end

	// Pending bits: held only while the input stays high, so sources must hold it
	wire [7:0] lvl_onehot  = 8'h01 << lvl;
	wire [7:0] take_set    = (last_fall & lvl_valid & svc_owner) ? lvl_onehot : vip_pkg::BYTE_ZERO;
	wire [7:0] req_set     = level_mode ? pin.req : (pin.req & ~req_prev);
	wire [7:0] next_pending = ((pending_request_reg & pin.req) & ~take_set) | req_set;

	// Release sources: automatic at the last pulse end, or by command
	wire [7:0] release_target = pin.data[vip_pkg::OPW_SPECIFIC] ? (8'h01 << pin.data[2:0])
		: (svc_pick[3] ? (8'h01 << svc_pick[2:0]) : vip_pkg::BYTE_ZERO);
	wire [7:0] release_clr = (wr_release & pin.data[vip_pkg::OPW_RELEASE]) ? release_target : vip_pkg::BYTE_ZERO;
	wire [7:0] auto_clr    = (last_rise & auto_release & lvl_valid & svc_owner) ? lvl_onehot : vip_pkg::BYTE_ZERO;
	wire [7:0] next_svc    = (in_service_reg & ~(release_clr | auto_clr)) | take_set;

	// Set wins over any clear arriving in the same cycle
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			pending_request_reg <= vip_pkg::BYTE_ZERO;
			in_service_reg      <= vip_pkg::BYTE_ZERO;
		end else begin
			pending_request_reg <= next_pending;
			in_service_reg      <= next_svc;
		end
	end

	// Interrupt held off during a sequence and before init completes
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s)
			INT <= 1'h0;
		else
			INT <= eligible & (pulse_idx == vip_pkg::PULSE_NONE) & (state == vip_pkg::ST_READY);
	end

	// Vector byte formats
	wire [7:0] vec_low  = interval4 ? {init_word_first[7:5], lvl, 2'h0} : {init_word_first[7:6], lvl, 3'h0};
	wire [7:0] vec_ptr  = {init_word_second[7:3], lvl};
	wire [7:0] poll_byte = {eligible, 4'h0, req_pick[2:0]};
	wire [7:0] status   = pin.a0 ? request_mask_reg
		: (poll_armed ? poll_byte : (read_svc ? in_service_reg : pending_request_reg));

	// Byte per pulse; a cascade master leaves vector bytes to the slave
	always_comb begin
		ack_drive = 1'h0;
		ack_byte  = vip_pkg::BYTE_ZERO;
		case (pulse_idx)
			vip_pkg::PULSE_FIRST: begin
				ack_drive = ~pointer_mode & ~is_slave;
				ack_byte  = vip_pkg::CALL_OPCODE;
			end
			vip_pkg::PULSE_SECOND: begin
				ack_drive = drive_me;
				ack_byte  = pointer_mode ? vec_ptr : vec_low;
			end
			vip_pkg::PULSE_THIRD: begin
				ack_drive = drive_me & ~pointer_mode;
				ack_byte  = init_word_second;
			end
			default: begin
				ack_drive = 1'h0;
				ack_byte  = vip_pkg::BYTE_ZERO;
			end
		endcase
	end

	wire       next_oe   = ack_low ? ack_drive : rd_active;
	wire [7:0] next_dout = ack_low ? ack_byte : status;

	// Data bus driven from flops to keep the pins glitch free
	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			D_OUT <= vip_pkg::BYTE_ZERO;
			D_OE  <= 1'h0;
		end else begin
			D_OUT <= next_dout;
			D_OE  <= next_oe;
		end
	end

	// Cascade identity and buffer enable
	assign CASCADE_ID_LINES_OUT           = lvl;
	assign CASCADE_ID_LINES_OE            = ~is_slave & cascaded & (pulse_idx != vip_pkg::PULSE_NONE);
	assign MASTER_SELECT_OR_BUFFER_EN_OE  = buffered;
	assign MASTER_SELECT_OR_BUFFER_EN_OUT = ~D_OE;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n_s);

	a_read_mask: assert property (rd_active && pin.a0 && !ack_low |=> D_OE && D_OUT == request_mask_reg)
		else $error("mask read not driven");
	a_bus_idle: assert property (!rd_active && !ack_low |=> !D_OE)
		else $error("bus driven while idle");
	a_pend_set: assert property (|req_set |=> (pending_request_reg & $past(req_set)) == $past(req_set))
		else $error("pending bit not set");
	a_int_gate: assert property (INT |-> $past(|(pending_request_reg & ~request_mask_reg)))
		else $error("interrupt without unmasked request");
	a_call_byte: assert property (ack_low && pulse_idx == vip_pkg::PULSE_FIRST && !pointer_mode && !is_slave
		|=> D_OE && D_OUT == 8'hCD)
		else $error("call opcode wrong");
	a_low_vec: assert property (ack_low && pulse_idx == vip_pkg::PULSE_SECOND && !pointer_mode && drive_me
		|=> D_OE && D_OUT[4:2] == (interval4 ? $past(lvl) : {$past(lvl[1:0]), 1'h0}))
		else $error("low vector byte wrong");
	a_high_vec: assert property (ack_low && pulse_idx == vip_pkg::PULSE_THIRD && drive_me
		|=> D_OUT == init_word_second)
		else $error("high vector byte wrong");
	a_ptr_hiz: assert property (ack_low && pulse_idx == vip_pkg::PULSE_FIRST && pointer_mode |=> !D_OE)
		else $error("bus driven on pointer first pulse");
	a_ptr_vec: assert property (ack_low && pulse_idx == vip_pkg::PULSE_SECOND && pointer_mode && drive_me
		|=> D_OUT == {init_word_second[7:3], lvl})
		else $error("pointer byte wrong");
	a_svc_set: assert property (last_fall && lvl_valid && svc_owner |=> in_service_reg[lvl]
		&& !pending_request_reg[lvl] || level_mode)
		else $error("service bit not taken");
	a_no_svc: assert property (last_fall && !lvl_valid && !wr_release |=> in_service_reg == $past(in_service_reg))
		else $error("service bit set for vanished request");
	a_auto_clr: assert property (last_rise && auto_release && lvl_valid && svc_owner |=> !in_service_reg[lvl])
		else $error("auto release missed");

endmodule

// File: vip_pkg.sv
// Shared constants and types for the vectored interrupt acknowledge port.
// Assumes a single system clock domain; all pins are synchronised before use.
package vip_pkg;

	// Fixed opcode returned on the first acknowledge of a call-vector sequence
	localparam logic [7:0] CALL_OPCODE   = 8'hCD;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam logic [2:0] LEVEL_DEFAULT = 3'h7;

	// First init word fields
	localparam int FIRST_NEED_W4 = 0;
	localparam int FIRST_SINGLE  = 1;
	localparam int FIRST_SPACING = 2;
	localparam int FIRST_LEVEL   = 3;
	localparam int FIRST_SELECT  = 4;

	// Operation word steering and fields
	localparam int OPW_SELECT3  = 3;
	localparam int OPW_RELEASE  = 5;
	localparam int OPW_SPECIFIC = 6;
	localparam int OPW_READ_SVC = 0;
	localparam int OPW_READ_SET = 1;
	localparam int OPW_POLL     = 2;

	// Fourth init word fields
	localparam int FOURTH_POINTER = 0;
	localparam int FOURTH_AUTO    = 1;
	localparam int FOURTH_MASTER  = 2;
	localparam int FOURTH_BUFFER  = 3;

	// Acknowledge pulse numbering within a sequence
	localparam logic [1:0] PULSE_NONE   = 2'h0;
	localparam logic [1:0] PULSE_FIRST  = 2'h1;
	localparam logic [1:0] PULSE_SECOND = 2'h2;
	localparam logic [1:0] PULSE_THIRD  = 2'h3;

	// Initialisation progress, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_UNINIT = 3'h0,
		ST_W2     = 3'h1,
		ST_W3     = 3'h3,
		ST_W4     = 3'h2,
		ST_READY  = 3'h6
	} vip_init_t;

	// Host and request pins as one bundle for synchronisation
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       a0;
		logic       ack_n;
		logic       sp;
		logic [2:0] cas;
		logic [7:0] data;
		logic [7:0] req;
	} vip_pins_t;

	// Idle level of the pins: strobes and selects high, rest low
	localparam vip_pins_t PINS_IDLE = 25'h1D80000;

endpackage

// File: vip_sync3.sv
// Three-stage synchroniser bank with agreement filter.
// Assumes reset is already synchronous to clk on release.
module vip_sync3 #(
	parameter int               WIDTH = 25,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] ff1;
	logic [WIDTH-1:0] ff2;
	logic [WIDTH-1:0] ff3;
	logic [WIDTH-1:0] next_q;

	// Refuse a width the bank cannot serve
	initial begin
		if (WIDTH < 1)
			$error("vip_sync3 needs WIDTH of at least one");
	end

	// Output moves only when stages two and three agree
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign next_q[i] = (ff2[i] == ff3[i]) ? ff3[i] : q[i];
	end

	// Stage one feeds stage two only, never the filter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1 <= INIT;
			ff2 <= INIT;
			ff3 <= INIT;
			q   <= INIT;
		end else begin
			ff1 <= d;
			ff2 <= ff1;
			ff3 <= ff2;
			q   <= next_q;
		end
	end

endmodule

// File: vip_host_model.sv
// Host processor model: command writes, status reads and acknowledge pulses.
// Assumes one calling process; every pin changes on a falling edge of the clock.
module vip_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] d_out,
	input  wire logic       d_oe,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            a0,
	output logic      [7:0] d_in,
	output logic            ack_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// Eight clocks per strobe phase, double what the pin synchroniser needs
	localparam int HOLD = 8;

	// Idle pins from time zero
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		a0 = 1'b0;
		d_in = 8'h00;
		ack_n = 1'b1;
	end

	// Write; released bus shows the inverse so a stale byte cannot pass
	task automatic wr(input logic addr, input logic [7:0] data);
		@(negedge clk_sys);
		cs_n = 1'b0;
		a0 = addr;
		d_in = data;
		wr_n = 1'b0;
		repeat (HOLD) @(negedge clk_sys);
		wr_n = 1'b1;
		repeat (HOLD) @(negedge clk_sys);
		cs_n = 1'b1;
		d_in = ~data;
		repeat (HOLD) @(negedge clk_sys);
	endtask

	// Read; an undriven bus is returned as unknown
	task automatic rd(input logic addr, output logic [7:0] data);
		@(negedge clk_sys);
		cs_n = 1'b0;
		a0 = addr;
		rd_n = 1'b0;
		repeat (HOLD) @(negedge clk_sys);
		data = (d_oe === 1'b1) ? d_out : 8'hXX;
		rd_n = 1'b1;
		cs_n = 1'b1;
		repeat (HOLD) @(negedge clk_sys);
	endtask

	// Acknowledge pulse with chip select left high
	task automatic ack(output logic [7:0] data);
		@(negedge clk_sys);
		ack_n = 1'b0;
		repeat (HOLD) @(negedge clk_sys);
		data = (d_oe === 1'b1) ? d_out : 8'hXX;
		ack_n = 1'b1;
		repeat (HOLD) @(negedge clk_sys);
	endtask
endmodule

// File: vip_ack_port_test.sv
// Self-checking bench for the acknowledge port, with the host model on the bus.
// Assumes the design answers within twice the synchroniser delay of each strobe.
module vip_ack_port_test;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int LIMIT = 10000;
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] req = 8'h00;
	logic       cs_n, rd_n, wr_n, a0, ack_n, d_oe, irq;
	logic [7:0] d_in, d_out;
	logic       sp = 1'b1;
	logic [2:0] cas_in = 3'h0;
	logic [2:0] cas_out;
	logic       cas_oe, en_out, en_oe;
	int         errors = 0;
	int         n_checks = 0;
	int         cycles = 0;

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	vip_host_model host (
		.clk_sys (clk_sys),
		.d_out   (d_out),
		.d_oe    (d_oe),
		.cs_n    (cs_n),
		.rd_n    (rd_n),
		.wr_n    (wr_n),
		.a0      (a0),
		.d_in    (d_in),
		.ack_n   (ack_n)
	);

	// Strap and cascade lines driven so master and slave roles can both be reached
	vip_ack_port uut (
		.CLK_SYS                        (clk_sys),
		.RST_N                          (rst_n),
		.CS_N                           (cs_n),
		.RD_N                           (rd_n),
		.WR_N                           (wr_n),
		.A0                             (a0),
		.D_IN                           (d_in),
		.D_OUT                          (d_out),
		.D_OE                           (d_oe),
		.HOST_ACK_PULSE_N               (ack_n),
		.REQUEST_INPUTS                 (req),
		.INT                            (irq),
		.CASCADE_ID_LINES_IN            (cas_in),
		.CASCADE_ID_LINES_OUT           (cas_out),
		.CASCADE_ID_LINES_OE            (cas_oe),
		.MASTER_SELECT_OR_BUFFER_EN_IN  (sp),
		.MASTER_SELECT_OR_BUFFER_EN_OUT (en_out),
		.MASTER_SELECT_OR_BUFFER_EN_OE  (en_oe)
	);

	task automatic results();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors = errors + 1;
			results();
		end
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rd_chk(input logic addr, input string name, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(addr, d);
		chk(name, exp, d);
	endtask

	task automatic ack_chk(input string name, input logic [7:0] exp);
		logic [7:0] d;
		host.ack(d);
		chk(name, exp, d);
	endtask

	// Reset held eight clocks, then time for the pin synchronisers
	task automatic init(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w4);
		req = 8'h00;
		rst_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (10) @(negedge clk_sys);
		host.wr(1'b0, w1);
		host.wr(1'b1, w2);
		if (w1[0])
			host.wr(1'b1, w4);
	endtask

	// Bounded wait for the interrupt output
	task automatic wait_int();
		for (int i = 0; i < 40 && irq !== 1'b1; i++)
			@(negedge clk_sys);
		chk("int", 8'h01, {7'h00, irq});
	endtask

	// Call mode, spacing four, two inputs raised, explicit release
	task automatic t_call4();
		init(8'hB6, 8'h3C, 8'h00);
		chk("idle bus", 8'h00, {7'h00, d_oe});
		req = 8'h24;
		wait_int();
		rd_chk(1'b0, "pending", 8'h24);
		ack_chk("opcode", 8'hCD);
		req = 8'h00;
		ack_chk("low byte 4", 8'hA8);
		ack_chk("high byte", 8'h3C);
		host.wr(1'b0, 8'h0B);
		rd_chk(1'b0, "service", 8'h04);
		host.wr(1'b0, 8'h20);
		rd_chk(1'b0, "released", 8'h00);
	endtask

	// Masked input must not interrupt until unmasked
	task automatic t_mask();
		init(8'hB6, 8'h3C, 8'h00);
		host.wr(1'b1, 8'h04);
		req = 8'h04;
		repeat (20) @(negedge clk_sys);
		chk("masked int", 8'h00, {7'h00, irq});
		rd_chk(1'b1, "mask", 8'h04);
		host.wr(1'b1, 8'h00);
		wait_int();
	endtask

	// Call mode, spacing eight, auto release, buffered master; request held so pending clear is seen
	task automatic t_call8_auto();
		init(8'hB3, 8'h3C, 8'h0E);
		chk("buffer en", 8'h03, {6'h00, en_oe, en_out});
		req = 8'h40;
		wait_int();
		ack_chk("opcode", 8'hCD);
		ack_chk("low byte 8", 8'hB0);
		ack_chk("high byte", 8'h3C);
		rd_chk(1'b0, "pending taken", 8'h00);
		req = 8'h00;
		host.wr(1'b0, 8'h0B);
		rd_chk(1'b0, "auto service", 8'h00);
	endtask

	// Pointer mode, automatic release; first pulse must leave the bus released
	task automatic t_ptr_auto();
		init(8'hB3, 8'h48, 8'h03);
		req = 8'h20;
		wait_int();
		ack_chk("first released", 8'hXX);
		req = 8'h00;
		ack_chk("pointer", 8'h4D);
		host.wr(1'b0, 8'h0B);
		rd_chk(1'b0, "auto service", 8'h00);
	endtask

	// Request withdrawn early, then a kept in-service bit without auto release
	task automatic t_ptr_noise();
		init(8'hB3, 8'h48, 8'h01);
		req = 8'h08;
		wait_int();
		req = 8'h00;
		repeat (10) @(negedge clk_sys);
		ack_chk("first released", 8'hXX);
		ack_chk("noise pointer", 8'h4F);
		host.wr(1'b0, 8'h0B);
		rd_chk(1'b0, "noise service", 8'h00);
		req = 8'h02;
		wait_int();
		ack_chk("first released", 8'hXX);
		req = 8'h00;
		ack_chk("pointer", 8'h49);
		rd_chk(1'b0, "kept service", 8'h02);
	endtask

	// Cascade: master defers later bytes to its slave, then a slave answers on its identity
	task automatic t_cascade();
		init(8'hB4, 8'h3C, 8'h00);
		host.wr(1'b1, 8'h04);
		req = 8'h04;
		wait_int();
		ack_chk("master opcode", 8'hCD);
		req = 8'h00;
		chk("cascade id", 8'h0A, {4'h0, cas_oe, cas_out});
		ack_chk("master low", 8'hXX);
		ack_chk("master high", 8'hXX);
		chk("cascade off", 8'h00, {7'h00, cas_oe});
		sp = 1'b0;
		cas_in = 3'h5;
		init(8'hB4, 8'h3C, 8'h00);
		host.wr(1'b1, 8'h05);
		req = 8'h08;
		wait_int();
		ack_chk("slave first", 8'hXX);
		req = 8'h00;
		ack_chk("slave low", 8'hAC);
		ack_chk("slave high", 8'h3C);
		chk("slave id lines", 8'h00, {7'h00, cas_oe});
	endtask

	// Main sequence
	initial begin
		t_call4();
		t_mask();
		t_call8_auto();
		t_ptr_auto();
		t_ptr_noise();
		t_cascade();
		results();
	end
endmodule
